// >>> hdl/pfp_map.svh
// Register map, field positions and reset values of the programmable flag port
`ifndef PFP_MAP_SVH
`define PFP_MAP_SVH

`define PFP_ADDR_W          4
`define PFP_PIN_W           8
`define PFP_CFG_W           4
`define PFP_OFS_DIR         4'h0
`define PFP_OFS_VAL         4'h4
`define PFP_OFS_FIXED       4'h8
`define PFP_OFS_STRAP       4'hC
`define PFP_DIR_RST         8'h00
`define PFP_VAL_RST         8'h00
`define PFP_FIXED_RST       3'h0
`define PFP_BOOT_HOSTPORT   4'h5
`define PFP_UNMAPPED_RD     32'h0000_0000

`endif

// >>> hdl/pfp_pkg.sv
// Types shared by the programmable flag port modules
package pfp_pkg;

    typedef enum {
        PFP_ST_IDLE,
        PFP_ST_ANSWER
    } pfp_bus_st_t;

    typedef enum {
        PFP_BOOT_OTHER,
        PFP_BOOT_HOST
    } pfp_boot_t;

endpackage

// >>> hdl/pfp_sync_if.sv
// Interface carrying pin samples and strap latching between the port modules
`timescale 1ns/10ps
interface pfp_sync_if;
    logic [7:0] raw;
    logic [7:0] synced;
    logic       strap_req;
    logic [3:0] strap_val;
    logic       strap_done;

    modport core (
        output raw,
        output strap_req,
        input  synced,
        input  strap_val,
        input  strap_done
    );
    modport sync (
        input  raw,
        input  strap_req,
        output synced,
        output strap_val,
        output strap_done
    );
endinterface

// >>> hdl/pfp_sync.sv
// Two-stage pin synchroniser and reset-time strap latch
`timescale 1ns/10ps
`include "pfp_map.svh"
module pfp_sync
    import pfp_pkg::*;
(
    // Clock and reset
    input  wire logic CLK_SYS_IN,
    input  wire logic NRST_IN,
    // Pin samples
    pfp_sync_if.sync  sif
);
    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] stable;
        logic [3:0] strap;
        logic       done;
    } pfp_sync_st_t;

    pfp_sync_st_t st_ff;
    pfp_sync_st_t nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = sif.raw;
        nxt_st.stable = st_ff.meta;
        // Strap taken from synchronised pins while strap_req is high, at the third clock edge after reset release
        if (sif.strap_req) begin
            nxt_st.strap = st_ff.stable[`PFP_CFG_W-1:0];  // see [R9]
            nxt_st.done  = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sif.synced     = st_ff.stable;  // see [R4]
    assign sif.strap_val  = st_ff.strap;
    assign sif.strap_done = st_ff.done;
endmodule

// >>> hdl/pfp_top.sv
// Programmable flag port: eight direction-selectable pins with Avalon-MM registers
// What this block does
// [R1] Eight pins, each input or output
// [R2] Direction bit 1 output, 0 input
// [R3] Value reads pin levels, writes output levels
// [R4] Input pins synchronised to processor clock
// [R5] Output bits read back driven value
// [R6] All pins inputs during reset
// [R7] Three fixed flags are always outputs
// [R8] Fixed in/out flags need alternate serial mode
// [R9] Low four pins latched as configuration at reset
// [R10] Emulator reset relatches mode like pin reset
// [R11] Configuration selects boot; host port holds execution
// [R12] Writes to input bits do not drive pins
`timescale 1ns/10ps
`include "pfp_map.svh"
module pfp_top
    import pfp_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        NRST_IN,
    input  wire logic        EMU_NRST_IN,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output logic      [31:0] AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // Programmable pins
    input  wire logic [7:0]  PINS_IN,
    output logic      [7:0]  PINS_OUT,
    output logic      [7:0]  PINS_OE_N_OUT,
    // Fixed flags
    output logic      [2:0]  FIXED_FLAGS_OUT,
    input  wire logic        SERIAL_ALT_IN,
    input  wire logic        FIXED_IN_PIN_IN,
    output logic             FIXED_OUT_PIN_OUT,
    // Boot configuration
    output logic      [3:0]  BOOT_MODE_OUT,
    output logic             BOOT_HOST_OUT,
    output logic             EXEC_HOLD_OUT,
    input  wire logic        PM_ZERO_WRITTEN_IN
);
    // =====================================================================
    // Reset combining
    // =====================================================================
    // Emulator chip reset acts exactly like the pin reset
    logic rst_n;
    assign rst_n = NRST_IN & EMU_NRST_IN;  // see [R10]

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        pfp_bus_st_t bus;
        logic [31:0] rdata;
        logic [7:0]  dir;
        logic [7:0]  val;
        logic [2:0]  fixed;
        logic        fixed_out;
        logic [1:0]  alt_meta;
        logic [1:0]  fin_meta;
        logic        arm;
        logic        strap_req;
        logic        hold;
    } pfp_state_t;

    pfp_state_t st_ff;
    pfp_state_t nxt_st;

    pfp_sync_if sif ();

    pfp_sync u_sync (
        .CLK_SYS_IN (CLK_SYS_IN),
        .NRST_IN    (rst_n),
        .sif        (sif)
    );

    // =====================================================================
    // Helpers
    // =====================================================================
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd, input logic be);
        merge_byte = be ? wd : old;
    endfunction

    function automatic logic is_boot_host(input logic [3:0] m);
        // Mode C=1, B=0, A=1 selects host memory port boot
        is_boot_host = (m[2:0] == 3'(`PFP_BOOT_HOSTPORT));
    endfunction

    logic [7:0] pin_level;
    logic       alt_sync;
    logic       boot_host;

    // Output bits show driven value, input bits the synchronised pin
    assign pin_level = (st_ff.dir & st_ff.val) | (~st_ff.dir & sif.synced);  // see [R5] see [R4] see [R3]
    assign alt_sync  = st_ff.alt_meta[1];
    assign boot_host = sif.strap_done & is_boot_host(sif.strap_val);

    assign sif.raw       = PINS_IN;
    assign sif.strap_req = st_ff.strap_req;

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.alt_meta  = {st_ff.alt_meta[0], SERIAL_ALT_IN};
        nxt_st.fin_meta  = {st_ff.fin_meta[0], FIXED_IN_PIN_IN};
        // One-shot strap request, one cycle late so the synchroniser holds pin samples, not its reset value
        nxt_st.arm       = 1'b1;
        nxt_st.strap_req = 1'b0;
        if (st_ff.arm && !sif.strap_done && !st_ff.strap_req) begin
            nxt_st.strap_req = 1'b1;  // see [R9]
        end
        if (sif.strap_done && boot_host && PM_ZERO_WRITTEN_IN) begin
            nxt_st.hold = 1'b0;  // see [R11]
        end
        if (sif.strap_done && !boot_host) begin
            nxt_st.hold = 1'b0;
        end
        case (st_ff.bus)
            PFP_ST_IDLE: begin
                if (AVS_WRITE_IN) begin
                    nxt_st.bus = PFP_ST_ANSWER;
                end else if (AVS_READ_IN) begin
                    case (AVS_ADDRESS_IN)
                        `PFP_OFS_DIR: begin
                            nxt_st.rdata = {24'h00_0000, st_ff.dir};
                        end
                        `PFP_OFS_VAL: begin
                            nxt_st.rdata = {24'h00_0000, pin_level};  // see [R3]
                        end
                        `PFP_OFS_FIXED: begin
                            nxt_st.rdata = {27'h000_0000, alt_sync & st_ff.fin_meta[1],
                                            st_ff.fixed_out, st_ff.fixed};
                        end
                        `PFP_OFS_STRAP: begin
                            nxt_st.rdata = {26'h000_0000, boot_host, sif.strap_done, sif.strap_val};
                        end
                        default: begin
                            nxt_st.rdata = `PFP_UNMAPPED_RD;
                        end
                    endcase
                    nxt_st.bus = PFP_ST_ANSWER;
                end
            end
            PFP_ST_ANSWER: begin
                // Write lands at the edge where the master sees waitrequest low
                if (AVS_WRITE_IN) begin
                    case (AVS_ADDRESS_IN)
                        `PFP_OFS_DIR: begin
                            nxt_st.dir = merge_byte(st_ff.dir, AVS_WRITEDATA_IN[7:0], AVS_BYTEENABLE_IN[0]);  // see [R2]
                        end
                        `PFP_OFS_VAL: begin
                            // Stored for all bits; only output bits reach pins
                            nxt_st.val = merge_byte(st_ff.val, AVS_WRITEDATA_IN[7:0], AVS_BYTEENABLE_IN[0]);  // see [R12]
                        end
                        `PFP_OFS_FIXED: begin
                            if (AVS_BYTEENABLE_IN[0]) begin
                                nxt_st.fixed     = AVS_WRITEDATA_IN[2:0];
                                nxt_st.fixed_out = AVS_WRITEDATA_IN[3];
                            end
                        end
                        default: begin
                            // Unmapped and read-only offsets ignore writes
                        end
                    endcase
                end
                nxt_st.bus = PFP_ST_IDLE;
            end
            default: begin
                nxt_st.bus = PFP_ST_IDLE;
            end
        endcase
    end

    // =====================================================================
    // Registers
    // =====================================================================
    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) begin
            st_ff           <= '0;
            st_ff.bus       <= PFP_ST_IDLE;
            st_ff.dir       <= `PFP_DIR_RST;  // see [R6]
            st_ff.val       <= `PFP_VAL_RST;
            st_ff.fixed     <= `PFP_FIXED_RST;
            st_ff.hold      <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign AVS_WAITREQUEST_OUT = (AVS_READ_IN | AVS_WRITE_IN) & (st_ff.bus != PFP_ST_ANSWER);
    assign AVS_READDATA_OUT    = st_ff.rdata;
    assign PINS_OUT            = st_ff.val;
    assign PINS_OE_N_OUT       = ~st_ff.dir;  // see [R1] see [R2] see [R12]
    assign FIXED_FLAGS_OUT     = st_ff.fixed;  // see [R7]
    assign FIXED_OUT_PIN_OUT   = alt_sync & st_ff.fixed_out;  // see [R8]
    assign BOOT_MODE_OUT       = sif.strap_val;
    assign BOOT_HOST_OUT       = boot_host;
    assign EXEC_HOLD_OUT       = st_ff.hold;
endmodule

// >>> verification/pfp_board.sv
// Board model on the flag pins: echoes device drive, otherwise board levels
`timescale 1ns/10ps
module pfp_board (
    // Device side
    input  wire logic [7:0] oe_n_in,
    input  wire logic [7:0] drv_in,
    // Board side
    input  wire logic [7:0] ext_in,
    input  wire logic [3:0] strap_in,
    input  wire logic       hold_in,
    output logic      [7:0] pins_out
);
    // Straps sit on the low pins while hold_in is high
    assign pins_out = (~oe_n_in & drv_in) | (oe_n_in & (hold_in ? {ext_in[7:4], strap_in} : ext_in));
endmodule

// >>> verification/pfp_top_chk.sv
// Assertion checker on the flag port top ports
`timescale 1ns/10ps
module pfp_chk (
    // Clock and resets
    input wire logic        CLK_SYS_IN,
    input wire logic        NRST_IN,
    input wire logic        EMU_NRST_IN,
    // Bus and pins
    input wire logic [3:0]  AVS_ADDRESS_IN,
    input wire logic        AVS_READ_IN,
    input wire logic        AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic        AVS_WAITREQUEST_OUT,
    input wire logic [7:0]  PINS_OUT,
    input wire logic [7:0]  PINS_OE_N_OUT,
    input wire logic [3:0]  BOOT_MODE_OUT,
    input wire logic        BOOT_HOST_OUT
);
    logic       rst_n;
    logic       rd_ok;
    logic       wr_ok;
    logic [2:0] cyc_ff;
    assign rst_n = NRST_IN & EMU_NRST_IN;
    assign rd_ok = AVS_READ_IN & ~AVS_WAITREQUEST_OUT;
    assign wr_ok = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;
    // Cycles since the last reset release, saturating
    always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
        if (!rst_n) cyc_ff <= 3'h0;
        else if (cyc_ff != 3'h7) cyc_ff <= cyc_ff + 3'h1;
    end
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (!rst_n);
    property p_dir; wr_ok && AVS_ADDRESS_IN == 4'h0 |=> PINS_OE_N_OUT == ~$past(AVS_WRITEDATA_IN[7:0]); endproperty
    a_dir: assert property (p_dir) else $error("direction write not on enables");
    property p_val; wr_ok && AVS_ADDRESS_IN == 4'h4 |=> PINS_OUT == $past(AVS_WRITEDATA_IN[7:0]); endproperty
    a_val: assert property (p_val) else $error("value write not on pins");
    property p_rb; rd_ok && AVS_ADDRESS_IN == 4'h4 |-> (AVS_READDATA_OUT[7:0] & ~PINS_OE_N_OUT) == (PINS_OUT & ~PINS_OE_N_OUT); endproperty
    a_rb: assert property (p_rb) else $error("output bits misread");
    property p_up; rd_ok |-> AVS_READDATA_OUT[31:8] == 24'h0; endproperty
    a_up: assert property (p_up) else $error("upper read bits set");
    property p_ans; (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT; endproperty
    a_ans: assert property (p_ans) else $error("no answer after one wait");
    property p_host; cyc_ff == 3'h7 |-> BOOT_HOST_OUT == (BOOT_MODE_OUT[2:0] == 3'h5); endproperty
    a_host: assert property (p_host) else $error("host boot decode wrong");
    property p_rst; cyc_ff == 3'h1 |-> PINS_OE_N_OUT == 8'hFF && PINS_OUT == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("pins driven after reset");
    property p_strap; cyc_ff == 3'h7 |-> $stable(BOOT_MODE_OUT); endproperty
    a_strap: assert property (p_strap) else $error("strap changed after latch");
endmodule
bind pfp_top pfp_chk u_pfp_chk (.CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .EMU_NRST_IN(EMU_NRST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
    .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .PINS_OUT(PINS_OUT), .PINS_OE_N_OUT(PINS_OE_N_OUT),
    .BOOT_MODE_OUT(BOOT_MODE_OUT), .BOOT_HOST_OUT(BOOT_HOST_OUT));

// >>> verification/tb_programmable_flag_port.sv
// Self-checking bench for the programmable flag port
`timescale 1ns/10ps
module tb_programmable_flag_port;
    logic        clk = 1'b0, nrst = 1'b0, enrst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic        alt = 1'b0, fin = 1'b0, pmz = 1'b0, hold = 1'b1, wq, fout, host, hld;
    logic [3:0]  addr = 4'h0, strap = 4'h5, mode;
    logic [31:0] wdat = 32'h0, ro, rng = 32'h07E277CA;
    logic [7:0]  ext = 8'h00, pins, pout, oen;
    logic [2:0]  ff;
    int          n_fail = 0, checked = 0, m_dir, m_val, m_ext, k;
    always #5 clk = ~clk;
    pfp_board u_pfp_board (.oe_n_in(oen), .drv_in(pout), .ext_in(ext), .strap_in(strap), .hold_in(hold),
        .pins_out(pins));
    pfp_top u_pfp_top (.CLK_SYS_IN(clk), .NRST_IN(nrst), .EMU_NRST_IN(enrst), .AVS_ADDRESS_IN(addr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat), .AVS_BYTEENABLE_IN(4'hF),
        .AVS_READDATA_OUT(ro), .AVS_WAITREQUEST_OUT(wq), .PINS_IN(pins), .PINS_OUT(pout), .PINS_OE_N_OUT(oen),
        .FIXED_FLAGS_OUT(ff), .SERIAL_ALT_IN(alt), .FIXED_IN_PIN_IN(fin), .FIXED_OUT_PIN_OUT(fout),
        .BOOT_MODE_OUT(mode), .BOOT_HOST_OUT(host), .EXEC_HOLD_OUT(hld), .PM_ZERO_WRITTEN_IN(pmz));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic tally_and_finish();
        $display("checked %0d, failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wq === 1'b0) break;
        end
        q = ro;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic rdx(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wrx(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        hold <= 1'b0;
        rdx(4'h0, 32'h0);
        chk({24'h0, oen}, 32'hFF);
        rdx(4'hC, 32'h35);
        chk({28'h0, mode}, 32'h5);
        chk({31'h0, host}, 32'h1);
        chk({31'h0, hld}, 32'h1);
        pmz <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, hld}, 32'h0);
        $display("test reset done");
        for (k = 0; k < 24; k++) begin
            rng = xs(rng);
            m_val = rng[7:0];
            m_dir = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : rng[15:8];
            m_ext = rng[23:16];
            wrx(4'h4, m_val);
            wrx(4'h0, m_dir);
            ext <= rng[23:16];
            repeat (3) @(posedge clk);
            rdx(4'h4, (m_dir & m_val) | (~m_dir & m_ext & 8'hFF));
            chk({24'h0, oen}, ~m_dir & 8'hFF);
            chk({24'h0, pout & m_dir[7:0]}, m_val & m_dir);
            chk({24'h0, pout}, m_val);
        end
        $display("test pins done");
        wrx(4'h8, 32'h0F);
        repeat (3) @(posedge clk);
        chk({29'h0, ff}, 32'h7);
        chk({31'h0, fout}, 32'h0);
        alt <= 1'b1;
        fin <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, fout}, 32'h1);
        rdx(4'h8, 32'h1F);
        wrx(4'hC, 32'h0);
        rdx(4'hC, 32'h35);
        rdx(4'h2, 32'h0);
        $display("test fixed done");
        strap <= 4'h2;
        hold <= 1'b1;
        pmz <= 1'b0;
        @(posedge clk);
        enrst <= 1'b0;
        repeat (2) @(posedge clk);
        enrst <= 1'b1;
        repeat (3) @(posedge clk);
        hold <= 1'b0;
        chk({24'h0, oen}, 32'hFF);
        rdx(4'hC, 32'h12);
        chk({28'h0, mode}, 32'h2);
        chk({31'h0, host}, 32'h0);
        chk({31'h0, hld}, 32'h0);
        $display("test emulator reset done");
        tally_and_finish();
    end
endmodule
